/* logic/port_pin_override_regs.svh */
// How it works
// - Plain pull-up only for direction/out/kill 0b010.
// - Pull-up override enable selects override value.
// - Driver enable follows direction bit normally.
// - Direction override enable selects override value.
// - Outvalue override drives pin when enabled.
// - Otherwise driven level is port output bit.
// - Toggle override inverts the stored output bit.
// - Input enable override sets input enable.
// - Otherwise sleep clamp disables digital input.
// - Function tap before synchronizer; functions synchronize.
// - Strobes per port; clock, clamp, kill shared.
// - Bit 4 kill disables every pull-up without override enable.
// - Async timer without external clock takes bit 7.
// - Bit 7 register bits read zero when taken.
// - Taken bit 7 is no general I/O.
// - Each pin n feeds pin-change source n.
`ifndef PORT_PIN_OVERRIDE_REGS_SVH
`define PORT_PIN_OVERRIDE_REGS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_DIRECTION   12'h000
`define OFS_OUTPUT      12'h004
`define OFS_INPUT       12'h008
`define OFS_CTRL        12'h00c
`define OFS_TIMER_SEL   12'h010

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BIT_PULLUP_KILL 4
`define BIT_ASYNC_SEL   5
`define BIT_EXT_CLK_SEL 6
`define BIT_CLOCK_PIN   7
`define RST_BYTE        8'h00
`define ZERO_WORD       32'h0000_0000

`endif

/* logic/port_pin_override_pkg.sv */
package port_pin_override_pkg;
  typedef logic [7:0]  port_byte_t;
  typedef logic [31:0] bus_word_t;
endpackage

/* logic/port_pin_override_mux.sv */
`timescale 1ns/10ps
`include "port_pin_override_regs.svh"

module port_pin_override_mux (
  // Clock, reset and enable
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              ce,
  // APB slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [11:0]                       paddr,
  input  wire port_pin_override_pkg::bus_word_t  pwdata,
  output port_pin_override_pkg::bus_word_t       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // Per-pin overrides from peripheral modules
  input  wire port_pin_override_pkg::port_byte_t pullup_override_en,
  input  wire port_pin_override_pkg::port_byte_t pullup_override_val,
  input  wire port_pin_override_pkg::port_byte_t direction_override_en,
  input  wire port_pin_override_pkg::port_byte_t direction_override_val,
  input  wire port_pin_override_pkg::port_byte_t outvalue_override_en,
  input  wire port_pin_override_pkg::port_byte_t outvalue_override_val,
  input  wire port_pin_override_pkg::port_byte_t port_bit_toggle_override,
  input  wire port_pin_override_pkg::port_byte_t input_enable_override_en,
  input  wire port_pin_override_pkg::port_byte_t input_enable_override_val,
  // Sleep controller and oscillator
  input  wire logic                              sleep_clamp,
  input  wire logic                              osc_amp_out,
  // Pads
  input  wire port_pin_override_pkg::port_byte_t pad_in,
  output port_pin_override_pkg::port_byte_t      pad_out,
  output port_pin_override_pkg::port_byte_t      pad_oe_n,
  output port_pin_override_pkg::port_byte_t      pullup_en,
  // Alternate-function taps
  output port_pin_override_pkg::port_byte_t      schmitt_tap_to_function,
  output port_pin_override_pkg::port_byte_t      pin_change_src,
  output logic                                   crystal_amp_output_pin
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  port_pin_override_pkg::port_byte_t pin_direction_bit_q;
  port_pin_override_pkg::port_byte_t pin_output_bit_q;
  port_pin_override_pkg::port_byte_t pin_output_bit_d;
  port_pin_override_pkg::port_byte_t controller_control_q;
  port_pin_override_pkg::port_byte_t async_timer_status_reg_q;
  port_pin_override_pkg::port_byte_t sync1_q;
  port_pin_override_pkg::port_byte_t pin_input_bit_q;
  port_pin_override_pkg::port_byte_t pad_out_q;
  port_pin_override_pkg::port_byte_t pad_oe_n_q;
  port_pin_override_pkg::port_byte_t pullup_q;
  port_pin_override_pkg::bus_word_t  prdata_q;
  logic                              takeover_q;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic access     = psel & penable & ce;
  wire logic wr         = access & pwrite;
  // Read data is loaded at the end of the setup phase so it stands when pready is sampled.
  wire logic rd_setup   = psel & ~penable & ~pwrite & ce;
  wire logic hit_dir    = (paddr == `OFS_DIRECTION);
  wire logic hit_out    = (paddr == `OFS_OUTPUT);
  wire logic hit_in     = (paddr == `OFS_INPUT);
  wire logic hit_ctrl   = (paddr == `OFS_CTRL);
  wire logic hit_timer  = (paddr == `OFS_TIMER_SEL);
  wire logic mapped     = hit_dir | hit_out | hit_in | hit_ctrl | hit_timer;
  wire port_pin_override_pkg::port_byte_t wbyte = pwdata[7:0];

  // The slave answers in the first access cycle; a frozen clock enable stalls it.
  assign pready  = ce;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // ****************************************************************
  // Pin control logic
  // ****************************************************************
  wire logic pullup_kill = controller_control_q[`BIT_PULLUP_KILL];
  // Crystal output mode only when the external clock option is off.
  wire logic takeover_d = async_timer_status_reg_q[`BIT_ASYNC_SEL] &
                          ~async_timer_status_reg_q[`BIT_EXT_CLK_SEL];
  wire port_pin_override_pkg::port_byte_t clock_mask =
    {takeover_q, 7'h00};

  // Pull-up only for input, output bit high, kill low.
  wire port_pin_override_pkg::port_byte_t pull_plain =
    ~pin_direction_bit_q & pin_output_bit_q & {8{~pullup_kill}};
  wire port_pin_override_pkg::port_byte_t pull_sel =
    (pullup_override_en & pullup_override_val) |
    (~pullup_override_en & pull_plain);
  wire port_pin_override_pkg::port_byte_t drive_sel =
    (direction_override_en & direction_override_val) |
    (~direction_override_en & pin_direction_bit_q);
  wire port_pin_override_pkg::port_byte_t value_sel =
    (outvalue_override_en & outvalue_override_val) |
    (~outvalue_override_en & pin_output_bit_q);
  wire port_pin_override_pkg::port_byte_t in_en_sel =
    (input_enable_override_en & input_enable_override_val) |
    (~input_enable_override_en & {8{~sleep_clamp}});

  // Bit 7 leaves the port entirely when taken: no pull-up, no input.
  wire port_pin_override_pkg::port_byte_t pull_fin  = pull_sel & ~clock_mask;
  wire port_pin_override_pkg::port_byte_t drive_fin = drive_sel | clock_mask;
  wire port_pin_override_pkg::port_byte_t value_fin =
    (value_sel & ~clock_mask) | ({8{osc_amp_out}} & clock_mask);
  wire port_pin_override_pkg::port_byte_t in_en_fin = in_en_sel & ~clock_mask;

  // The tap is taken before the port synchronizer on purpose; each function
  // synchronizes it itself unless it uses the tap as a clock.
  assign schmitt_tap_to_function = pad_in & in_en_fin;
  assign pin_change_src          = schmitt_tap_to_function;
  assign crystal_amp_output_pin  = takeover_q & osc_amp_out;

  assign pad_out   = pad_out_q;
  assign pad_oe_n  = pad_oe_n_q;
  assign pullup_en = pullup_q;

  // Software write, then bus toggle, then function toggle, all in one step.
  wire port_pin_override_pkg::port_byte_t out_written =
    (wr & hit_out) ? wbyte : pin_output_bit_q;
  wire port_pin_override_pkg::port_byte_t bus_toggle =
    (wr & hit_in) ? wbyte : `RST_BYTE;
  assign pin_output_bit_d = out_written ^ bus_toggle ^ port_bit_toggle_override;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire port_pin_override_pkg::port_byte_t rd_dir = pin_direction_bit_q & ~clock_mask;
  wire port_pin_override_pkg::port_byte_t rd_out = pin_output_bit_q & ~clock_mask;
  wire port_pin_override_pkg::port_byte_t rd_in  = pin_input_bit_q & ~clock_mask;
  wire port_pin_override_pkg::port_byte_t rd_byte =
    hit_dir   ? rd_dir :
    hit_out   ? rd_out :
    hit_in    ? rd_in :
    hit_ctrl  ? controller_control_q :
    hit_timer ? async_timer_status_reg_q : `RST_BYTE;

  // ****************************************************************
  // Clocked state
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bit_q      <= `RST_BYTE;
      pin_output_bit_q         <= `RST_BYTE;
      controller_control_q     <= `RST_BYTE;
      async_timer_status_reg_q <= `RST_BYTE;
      takeover_q               <= 1'b0;
    end else if (ce) begin
      if (wr & hit_dir) begin
        pin_direction_bit_q <= wbyte;
      end
      if (wr & hit_ctrl) begin
        controller_control_q <= wbyte;
      end
      if (wr & hit_timer) begin
        async_timer_status_reg_q <= wbyte;
      end
      pin_output_bit_q <= pin_output_bit_d;
      takeover_q       <= takeover_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q         <= `RST_BYTE;
      pin_input_bit_q <= `RST_BYTE;
    end else if (ce) begin
      sync1_q         <= pad_in;
      pin_input_bit_q <= sync1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out_q  <= `RST_BYTE;
      pad_oe_n_q <= ~`RST_BYTE;
      pullup_q   <= `RST_BYTE;
    end else if (ce) begin
      pad_out_q  <= value_fin;
      pad_oe_n_q <= ~drive_fin;
      pullup_q   <= pull_fin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= `ZERO_WORD;
    end else if (rd_setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  plain_pullup_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !pullup_override_en[0] && !pin_direction_bit_q[0] && pin_output_bit_q[0]
      && !pullup_kill |=> pullup_en[0])
    else $error("pull-up missing in plain input state");

  pullup_override_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && pullup_override_en[1] |=> pullup_en[1] == $past(pullup_override_val[1]))
    else $error("pull-up does not follow override value");

  driver_plain_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !direction_override_en[2] |=> pad_oe_n[2] == !$past(pin_direction_bit_q[2]))
    else $error("driver enable does not follow direction bit");

  driver_override_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && direction_override_en[3] |=> pad_oe_n[3] == !$past(direction_override_val[3]))
    else $error("driver enable does not follow override");

  value_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && outvalue_override_en[4] |=> pad_out[4] == $past(outvalue_override_val[4]))
    else $error("pin value does not follow override");

  toggle_invert_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && port_bit_toggle_override[5] && !wr |=>
      pin_output_bit_q[5] != $past(pin_output_bit_q[5]))
    else $error("toggle override did not invert output bit");

  sleep_clamp_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !input_enable_override_en[6] && sleep_clamp |-> !schmitt_tap_to_function[6])
    else $error("tap not clamped in sleep");

  kill_pullups_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && pullup_kill && pullup_override_en == 8'h00 |=> pullup_en == 8'h00)
    else $error("pull-up active while globally disabled");

  clock_pin_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup && takeover_q && (hit_dir || hit_out || hit_in) |=> prdata[7] == 1'b0)
    else $error("taken bit 7 reads nonzero");

  clock_pin_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && takeover_q |=> !pad_oe_n[7] && !pullup_en[7])
    else $error("taken bit 7 not routed to oscillator");

  outvalue_plain_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !outvalue_override_en[3] |=> pad_out[3] == $past(pin_output_bit_q[3]))
    else $error("pin value does not follow output bit");

  pullup_output_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !pullup_override_en[0] && pin_direction_bit_q[0] |=> !pullup_en[0])
    else $error("pull-up on while pin is an output");

  input_override_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    input_enable_override_en[1] |->
      schmitt_tap_to_function[1] == (pad_in[1] && input_enable_override_val[1]))
    else $error("input enable does not follow override");

  input_awake_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !input_enable_override_en[2] && !sleep_clamp |-> schmitt_tap_to_function[2] == pad_in[2])
    else $error("tap blocked while awake");

  change_source_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !input_enable_override_en[5] && !sleep_clamp |-> pin_change_src[5] == pad_in[5])
    else $error("pin-change source does not follow its pin");

  input_sync_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce ##1 ce |=> pin_input_bit_q == $past(pad_in, 2))
    else $error("input register is not the twice-synchronized pad");

  toggle_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !port_bit_toggle_override[6] && !wr |=> $stable(pin_output_bit_q[6]))
    else $error("output bit changed without write or toggle");

  frozen_state_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(pin_output_bit_q) && $stable(pad_out) && $stable(pad_oe_n)
      && $stable(pullup_en) && $stable(prdata))
    else $error("state moved while clock enable low");

  unmapped_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && !mapped |=> $stable(pin_direction_bit_q) && $stable(controller_control_q)
      && $stable(async_timer_status_reg_q))
    else $error("unmapped write changed a register");

  write_lands_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && hit_dir |=> pin_direction_bit_q == $past(wbyte))
    else $error("direction write did not land");

  read_upper_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_setup |=> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");

  // ****************************************************************
  // Bit 7 takeover checks
  // ****************************************************************
  takeover_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && async_timer_status_reg_q[`BIT_ASYNC_SEL]
      && !async_timer_status_reg_q[`BIT_EXT_CLK_SEL] |=> takeover_q)
    else $error("bit 7 not taken by the crystal amplifier");

  takeover_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && async_timer_status_reg_q[`BIT_EXT_CLK_SEL] |=> !takeover_q)
    else $error("bit 7 taken while external clock selected");

  clock_pin_value_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && takeover_q |=> pad_out[7] == $past(osc_amp_out))
    else $error("taken bit 7 does not carry the amplifier output");

  crystal_idle_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !takeover_q |-> !crystal_amp_output_pin)
    else $error("amplifier output shown while bit 7 is free");

  clock_pin_input_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    takeover_q |-> !schmitt_tap_to_function[7] && !pin_change_src[7])
    else $error("taken bit 7 still feeds the input tap");

  bit7_port_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && !takeover_q && !direction_override_en[7] |=>
      pad_oe_n[7] == !$past(pin_direction_bit_q[7]))
    else $error("free bit 7 driver does not follow direction bit");

endmodule

/* bench/override_source.sv */
`timescale 1ns/10ps

module override_source (
  // Clock and control from the bench
  input  wire logic        pclk,
  input  wire logic        active,
  input  wire logic [63:0] stim,
  input  wire logic [7:0]  toggle_req,
  input  wire logic [7:0]  tap,
  // Per-pin overrides
  output logic [7:0]       pullup_override_en,
  output logic [7:0]       pullup_override_val,
  output logic [7:0]       direction_override_en,
  output logic [7:0]       direction_override_val,
  output logic [7:0]       outvalue_override_en,
  output logic [7:0]       outvalue_override_val,
  output logic [7:0]       port_bit_toggle_override,
  output logic [7:0]       input_enable_override_en,
  output logic [7:0]       input_enable_override_val,
  // Tap as the function sees it after its own synchronizer
  output logic [7:0]       tap_sync
);
  logic [71:0] ovr_q;
  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;

  // An idle function must leave the pin to the plain port registers.
  always_ff @(posedge pclk) begin
    ovr_q <= active ? {toggle_req, stim} : 72'h0;
  end

  // The tap is raw, so the function brings it into its own domain.
  always_ff @(posedge pclk) begin
    sync1_q <= tap;
    sync2_q <= sync1_q;
  end

  assign pullup_override_en        = ovr_q[7:0];
  assign pullup_override_val       = ovr_q[15:8];
  assign direction_override_en     = ovr_q[23:16];
  assign direction_override_val    = ovr_q[31:24];
  assign outvalue_override_en      = ovr_q[39:32];
  assign outvalue_override_val     = ovr_q[47:40];
  assign input_enable_override_en  = ovr_q[55:48];
  assign input_enable_override_val = ovr_q[63:56];
  assign port_bit_toggle_override  = ovr_q[71:64];
  assign tap_sync                  = sync2_q;
endmodule

/* bench/port_pin_override_mux_tb_top.sv */
`timescale 1ns/10ps
`include "port_pin_override_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module port_pin_override_mux_tb_top;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sleep_clamp, osc, xpin;
  logic act, m_kill, m_taken, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, rs;
  logic [63:0] stim;
  logic [7:0] tog, pad_in, pad_out, pad_oe_n, pullup_en, tap, pcs, m_dir, m_out, tsync;
  logic [7:0] pue, puv, dde, ddv, pve, pvv, pto, iee, iev;
  int fail_count, check_count;

  port_pin_override_mux DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pullup_override_en(pue), .pullup_override_val(puv),
    .direction_override_en(dde), .direction_override_val(ddv), .outvalue_override_en(pve),
    .outvalue_override_val(pvv), .port_bit_toggle_override(pto),
    .input_enable_override_en(iee), .input_enable_override_val(iev),
    .sleep_clamp(sleep_clamp), .osc_amp_out(osc), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pullup_en(pullup_en), .schmitt_tap_to_function(tap),
    .pin_change_src(pcs), .crystal_amp_output_pin(xpin));

  override_source PEER (.pclk(pclk), .active(act), .stim(stim), .toggle_req(tog), .tap(tap),
    .pullup_override_en(pue), .pullup_override_val(puv), .direction_override_en(dde),
    .direction_override_val(ddv), .outvalue_override_en(pve), .outvalue_override_val(pvv),
    .port_bit_toggle_override(pto), .input_enable_override_en(iee),
    .input_enable_override_val(iev), .tap_sync(tsync));

  // ****************************************************************
  // Clock, helpers and bus tasks
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) osc <= ~osc;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Starts at the next rising edge, so two calls never drive psel in one step;
  // returns in the time step of the completing edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin fail_count++; report_and_stop(); end
    err = pslverr;
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("read", {24'h0, e}, q)
    `CHK("slverr", 1'b0, err)
  endtask

  // Pins follow the plain registers unless the function overrides them.
  task automatic check_pins();
    logic [63:0] s;
    logic [7:0] oe, pv, pu, ie, mk;
    s = act ? stim : 64'h0;
    oe = (s[23:16] & s[31:24]) | (~s[23:16] & m_dir);
    pv = (s[39:32] & s[47:40]) | (~s[39:32] & m_out);
    pu = (s[7:0] & s[15:8]) | (~s[7:0] & ~m_dir & m_out & {8{~m_kill}});
    ie = (s[55:48] & s[63:56]) | (~s[55:48] & {8{~sleep_clamp}});
    mk = m_taken ? 8'h7f : 8'hff;
    pu = pu & mk;
    ie = ie & mk;
    oe = oe | ~mk;
    `CHK("oe_n", ~oe, pad_oe_n)
    `CHK("pad_out", pv & oe & mk, pad_out & oe & mk)
    `CHK("pullup", pu, pullup_en)
    `CHK("tap", pad_in & ie, tap)
    `CHK("pcsrc", pad_in & ie, pcs)
    `CHK("tap_sync", pad_in & ie, tsync)
    if (m_taken) `CHK("xtal", osc, xpin)
    if (m_taken) `CHK("osc_out", ~osc, pad_out[7])
  endtask

  task automatic program_regs();
    apb(1'b1, `OFS_DIRECTION, {24'h0, m_dir});
    apb(1'b1, `OFS_OUTPUT, {24'h0, m_out});
    apb(1'b1, `OFS_CTRL, {27'h0, m_kill, 4'h0});
    repeat (3) @(posedge pclk);
    #1 check_pins();
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {ce, psel, penable, pwrite, paddr, pwdata, sleep_clamp, osc, act, tog} = '0;
    {stim, pad_in, m_dir, m_out, m_kill, m_taken, fail_count, check_count} = '0;
    ce = 1'b1;
    rs = 32'h179768cf;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1 `CHK("rst_oe_n", 8'hff, pad_oe_n)
    rchk(`OFS_DIRECTION, 8'h00);
    for (int k = 0; k < 2; k++) begin
      m_dir = 8'h00; m_out = 8'hff; m_kill = k[0];
      program_regs();
    end
    for (int i = 0; i < 40; i++) begin
      rs = xs(rs);
      pad_in <= rs[31:24];
      {m_kill, m_out, m_dir} = rs[23:7];
      act <= rs[1]; sleep_clamp <= rs[2];
      rs = xs(rs); stim[31:0] <= rs;
      rs = xs(rs); stim[63:32] <= rs;
      program_regs();
      rchk(`OFS_INPUT, pad_in);
    end
    act <= 1'b1;
    apb(1'b1, `OFS_INPUT, 32'h5a);
    tog <= 8'h81;
    @(posedge pclk);
    tog <= 8'h00;
    repeat (3) @(posedge pclk);
    rchk(`OFS_OUTPUT, m_out ^ 8'h5a ^ 8'h81);
    m_out = m_out ^ 8'hdb;
    apb(1'b1, 12'h014, 32'hff);
    `CHK("err", 1'b1, err)
    apb(1'b0, 12'h014, 32'h0);
    `CHK("unmapped", 32'h0, q)
    ce <= 1'b0;
    tog <= 8'h0f;
    repeat (4) @(posedge pclk);
    `CHK("stall", 1'b0, pready)
    tog <= 8'h00;
    @(posedge pclk);
    ce <= 1'b1;
    rchk(`OFS_OUTPUT, m_out);
    rchk(`OFS_DIRECTION, m_dir);
    apb(1'b1, `OFS_TIMER_SEL, 32'h20);
    m_taken = 1'b1;
    repeat (3) @(posedge pclk);
    #1 check_pins();
    rchk(`OFS_DIRECTION, m_dir & 8'h7f);
    rchk(`OFS_OUTPUT, m_out & 8'h7f);
    rchk(`OFS_INPUT, pad_in & 8'h7f);
    apb(1'b1, `OFS_TIMER_SEL, 32'h60);
    m_taken = 1'b0;
    repeat (3) @(posedge pclk);
    #1 check_pins();
    rchk(`OFS_DIRECTION, m_dir);
    report_and_stop();
  end
endmodule
